/* File: core/vfp_regs.svh */
// Register map and constants of the voltage and frequency protection
//
// Contract
// - Undervoltage starts per phase between block and start
// - Undervoltage voting off, one, two, all
// - Undervoltage start 30..130 default 52, block 0..20
// - Trip only after full delay, trip requested
// - Start-only option suppresses trip, resets false
// - Voltage delays 0..60000 ms, default 100
// - Blocking input holds start and trip inactive
// - Residual starts above threshold 2..60, default 30
// - Residual trip uses same definite delay
// - Period between consecutive rising zero crossings
// - Accept after four identical period measurements
// - Four invalid measurements force frequency zero
// - Measurement valid only above 30 percent voltage
// - Over-frequency starts after five values above setting
// - Over-frequency has configurable trip delay
// - Over-frequency enable; disabled keeps outputs inactive
// - Over-frequency blocking input holds outputs inactive
// - Over-frequency setting 40..60 Hz, 0.01 steps, 51
// - Overvoltage starts above threshold 30..130, default 63
`ifndef VFP_REGS_SVH
`define VFP_REGS_SVH
`define VFP_AW 8
`define VFP_CTRL 8'h00
`define VFP_OV_THR 8'h04
`define VFP_UV_THR 8'h08
`define VFP_RES_THR 8'h0C
`define VFP_OF_THR 8'h10
`define VFP_OV_DLY 8'h14
`define VFP_UV_DLY 8'h18
`define VFP_RES_DLY 8'h1C
`define VFP_OF_DLY 8'h20
`define VFP_STATUS 8'h24
`define VFP_PERIOD 8'h28
`define VFP_C_MODE 1:0
`define VFP_C_OV_EN 2
`define VFP_C_RES_EN 3
`define VFP_C_OF_EN 4
`define VFP_C_OV_SO 5
`define VFP_C_UV_SO 6
`define VFP_C_RES_SO 7
`define VFP_C_OF_SO 8
`define VFP_UV_ST 7:0
`define VFP_UV_BLK 15:8
`define VFP_OV_MIN 16'h001E
`define VFP_OV_MAX 16'h0082
`define VFP_OV_DEF 8'h3F
`define VFP_UV_MIN 16'h001E
`define VFP_UV_MAX 16'h0082
`define VFP_UV_DEF 8'h34
`define VFP_BLK_MIN 16'h0000
`define VFP_BLK_MAX 16'h0014
`define VFP_BLK_DEF 8'h0A
`define VFP_RES_MIN 16'h0002
`define VFP_RES_MAX 16'h003C
`define VFP_RES_DEF 8'h1E
`define VFP_OF_MIN 16'h0FA0
`define VFP_OF_MAX 16'h1770
`define VFP_OF_DEF 13'h13EC
`define VFP_DLY_MIN 16'h0000
`define VFP_DLY_MAX 16'hEA60
`define VFP_DLY_DEF 16'h0064
`define VFP_OFD_MIN 16'h0064
`define VFP_OFD_DEF 16'h00C8
`define VFP_T_OV 0
`define VFP_T_UV 1
`define VFP_T_RES 2
`define VFP_T_OF 3
`define VFP_CLK_NS 5
`define VFP_MS_NS 1000000
`define VFP_US_NS 1000
`define VFP_US_PER_S 1000000
`define VFP_F_MIN_HZ 40
`define VFP_F_MAX_HZ 70
`define VFP_CHZ_US 32'h05F5_E100
`define VFP_EVAL_PCT 8'h1E
`define VFP_ACCEPT_CNT 3'h4
`define VFP_INVALID_CNT 3'h4
`define VFP_OF_CNT 3'h5
`endif

/* File: core/vfp_pkg.sv */
// Types shared by the voltage and frequency protection block
package vfp_pkg;
	typedef enum logic [1:0] {UV_OFF, UV_ONE, UV_TWO, UV_ALL} vfp_uv_mode_e;
	typedef struct packed {
		logic [7:0] res;
		logic [2:0][7:0] ph;
	} vfp_volt_s;
	typedef struct packed {
		logic of;
		logic res;
		logic uv;
		logic ov;
	} vfp_blk_s;
	typedef struct packed {
		logic of_trip;
		logic of_start;
		logic res_trip;
		logic res_start;
		logic uv_trip;
		logic uv_gen;
		logic [2:0] uv_start;
		logic ov_trip;
		logic ov_gen;
		logic [2:0] ov_start;
	} vfp_out_s;
	typedef struct packed {
		logic [17:0] sub;
		logic [15:0] ms;
	} vfp_tmr_s;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		vfp_uv_mode_e uv_mode;
		logic [3:0] en;
		logic [3:0] so;
		logic [7:0] ov_thr;
		logic [7:0] uv_thr;
		logic [7:0] uv_blk;
		logic [7:0] res_thr;
		logic [12:0] of_thr;
		logic [3:0][15:0] dly;
		vfp_tmr_s [3:0] tmr;
		logic [7:0] us_sub;
		logic [15:0] per_cnt;
		logic armed;
		logic low_seen;
		logic [15:0] last_per;
		logic [2:0] same_cnt;
		logic [2:0] inv_cnt;
		logic [15:0] acc_per;
		logic [2:0] over_cnt;
		vfp_out_s out;
	} vfp_state_s;
endpackage : vfp_pkg

/* File: core/vfp_top.sv */
// Voltage and frequency protection decision logic with APB settings
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "vfp_regs.svh"
module vfp_top #(
	parameter int TICK_CYCLES = `VFP_MS_NS / `VFP_CLK_NS
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`VFP_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Magnitudes, blocking inputs, zero crossings
	input wire vfp_pkg::vfp_volt_s volt,
	input wire vfp_pkg::vfp_blk_s blk,
	input wire logic zero_cross,
	// Start and trip outputs
	output vfp_pkg::vfp_out_s prot
);
	localparam int US_CYCLES = `VFP_US_NS / `VFP_CLK_NS;
	localparam logic [15:0] PER_MIN =
		16'(`VFP_US_PER_S / `VFP_F_MAX_HZ);
	localparam logic [15:0] PER_MAX =
		16'(`VFP_US_PER_S / `VFP_F_MIN_HZ);
	localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);
	localparam logic [7:0] US_LAST = 8'(US_CYCLES - 1);

	function automatic vfp_pkg::vfp_state_s rst_state();
		vfp_pkg::vfp_state_s s;
		s = '0;
		s.uv_mode = vfp_pkg::UV_ONE;
		s.en = 4'hF;
		s.ov_thr = `VFP_OV_DEF;
		s.uv_thr = `VFP_UV_DEF;
		s.uv_blk = `VFP_BLK_DEF;
		s.res_thr = `VFP_RES_DEF;
		s.of_thr = `VFP_OF_DEF;
		s.dly[`VFP_T_OV] = `VFP_DLY_DEF;
		s.dly[`VFP_T_UV] = `VFP_DLY_DEF;
		s.dly[`VFP_T_RES] = `VFP_DLY_DEF;
		s.dly[`VFP_T_OF] = `VFP_OFD_DEF;
		return s;
	endfunction : rst_state

	localparam vfp_pkg::vfp_state_s RST_STATE = rst_state();

	// Out-of-range writes saturate rather than being refused
	function automatic logic [15:0] clamp(
		input logic [31:0] v,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		if (v < 32'(lo))
			return lo;
		else if (v > 32'(hi))
			return hi;
		else
			return v[15:0];
	endfunction : clamp

	// Definite delay timer; counts whole ms while the start holds
	// The ms count saturates, so a start held for hours cannot wrap
	// back under the delay and drop an issued trip
	// A run of 0 clears both counts at once: no partial time is kept
	function automatic vfp_pkg::vfp_tmr_s tmr_step(
		input vfp_pkg::vfp_tmr_s t,
		input logic run
	);
		vfp_pkg::vfp_tmr_s n;
		n = '0;
		if (run)
		begin
			n = t;
			if (t.sub == TICK_LAST)
			begin
				n.sub = '0;
				if (t.ms != 16'hFFFF)
					n.ms = t.ms + 16'h0001;
			end
			else
				n.sub = t.sub + 18'h0_0001;
		end
		return n;
	endfunction : tmr_step

	// Saturating count; the accept and invalid runs must not wrap
	function automatic logic [2:0] inc_sat(
		input logic [2:0] c,
		input logic [2:0] top
	);
		return (c >= top) ? top : c + 3'h1;
	endfunction : inc_sat

	// Phase voting of the undervoltage general start
	// Mode 0 gives no start whatever the phases show
	function automatic logic vote(
		input vfp_pkg::vfp_uv_mode_e m,
		input logic [2:0] p
	);
		logic [1:0] n;
		n = 2'(p[0]) + 2'(p[1]) + 2'(p[2]);
		case (m)
			vfp_pkg::UV_ONE: return n >= 2'h1;
			vfp_pkg::UV_TWO: return n >= 2'h2;
			vfp_pkg::UV_ALL: return n == 2'h3;
			default: return 1'b0;
		endcase
	endfunction : vote

	vfp_pkg::vfp_state_s st;
	vfp_pkg::vfp_state_s next_st;

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign prot = st.out;

	always_comb
	begin
		logic acc_ph;
		logic wr;
		logic hit;
		logic [31:0] rd;
		logic [2:0] ov_p;
		logic [2:0] uv_p;
		logic ov_g;
		logic uv_g;
		logic res_s;
		logic of_s;
		logic zc_ok;
		logic tout;
		logic [15:0] per;
		logic [28:0] prod;
		// Every local gets a value first so no latch is inferred
		ov_p = '0;
		uv_p = '0;
		ov_g = 1'b0;
		uv_g = 1'b0;
		res_s = 1'b0;
		of_s = 1'b0;
		zc_ok = 1'b0;
		tout = 1'b0;
		per = '0;
		prod = '0;
		next_st = st;
		acc_ph = psel & penable;
		wr = acc_ph & st.pready & pwrite;
		hit = 1'b1;
		rd = '0;
		// Address decode shared by read mux and error flag
		// Misaligned addresses fall through to the error branch
		if (paddr == `VFP_CTRL)
			rd = {23'h0, st.so, st.en[`VFP_T_OF], st.en[`VFP_T_RES],
				st.en[`VFP_T_OV], st.uv_mode};
		else if (paddr == `VFP_OV_THR)
			rd = {24'h0, st.ov_thr};
		else if (paddr == `VFP_UV_THR)
			rd = {16'h0, st.uv_blk, st.uv_thr};
		else if (paddr == `VFP_RES_THR)
			rd = {24'h0, st.res_thr};
		else if (paddr == `VFP_OF_THR)
			rd = {19'h0, st.of_thr};
		else if (paddr == `VFP_OV_DLY)
			rd = {16'h0, st.dly[`VFP_T_OV]};
		else if (paddr == `VFP_UV_DLY)
			rd = {16'h0, st.dly[`VFP_T_UV]};
		else if (paddr == `VFP_RES_DLY)
			rd = {16'h0, st.dly[`VFP_T_RES]};
		else if (paddr == `VFP_OF_DLY)
			rd = {16'h0, st.dly[`VFP_T_OF]};
		else if (paddr == `VFP_STATUS)
			rd = {18'h0, st.out};
		else if (paddr == `VFP_PERIOD)
			rd = {16'h0, st.acc_per};
		else
			hit = 1'b0;
		// Registered answer: one wait state, then pready for one cycle
		next_st.pready = acc_ph & ~st.pready;
		next_st.pslverr = acc_ph & ~st.pready & ~hit;
		next_st.prdata = (acc_ph & ~st.pready & ~pwrite) ? rd : '0;
		if (wr & hit)
		begin
			if (paddr == `VFP_CTRL)
			begin
				next_st.uv_mode =
					vfp_pkg::vfp_uv_mode_e'(pwdata[`VFP_C_MODE]);
				// Undervoltage has no enable bit; mode 0 disables it
				next_st.en = {pwdata[`VFP_C_OF_EN],
					pwdata[`VFP_C_RES_EN], 1'b1,
					pwdata[`VFP_C_OV_EN]};
				next_st.so = pwdata[`VFP_C_OF_SO:`VFP_C_OV_SO];
			end
			else if (paddr == `VFP_OV_THR)
				next_st.ov_thr =
					8'(clamp(pwdata, `VFP_OV_MIN, `VFP_OV_MAX));
			else if (paddr == `VFP_UV_THR)
			begin
				next_st.uv_thr = 8'(clamp({24'h0, pwdata[`VFP_UV_ST]},
					`VFP_UV_MIN, `VFP_UV_MAX));
				next_st.uv_blk = 8'(clamp({24'h0, pwdata[`VFP_UV_BLK]},
					`VFP_BLK_MIN, `VFP_BLK_MAX));
			end
			else if (paddr == `VFP_RES_THR)
				next_st.res_thr =
					8'(clamp(pwdata, `VFP_RES_MIN, `VFP_RES_MAX));
			else if (paddr == `VFP_OF_THR)
				next_st.of_thr =
					13'(clamp(pwdata, `VFP_OF_MIN, `VFP_OF_MAX));
			else if (paddr == `VFP_OV_DLY)
				next_st.dly[`VFP_T_OV] =
					clamp(pwdata, `VFP_DLY_MIN, `VFP_DLY_MAX);
			else if (paddr == `VFP_UV_DLY)
				next_st.dly[`VFP_T_UV] =
					clamp(pwdata, `VFP_DLY_MIN, `VFP_DLY_MAX);
			else if (paddr == `VFP_RES_DLY)
				next_st.dly[`VFP_T_RES] =
					clamp(pwdata, `VFP_DLY_MIN, `VFP_DLY_MAX);
			else if (paddr == `VFP_OF_DLY)
				next_st.dly[`VFP_T_OF] =
					clamp(pwdata, `VFP_OFD_MIN, `VFP_DLY_MAX);
		end

		// Voltage elements
		for (int i = 0; i < 3; i++)
		begin
			ov_p[i] = st.en[`VFP_T_OV] & ~blk.ov
				& (volt.ph[i] > st.ov_thr);
			uv_p[i] = (st.uv_mode != vfp_pkg::UV_OFF) & ~blk.uv
				& (volt.ph[i] < st.uv_thr)
				& (volt.ph[i] > st.uv_blk);
		end
		ov_g = |ov_p;
		uv_g = vote(st.uv_mode, uv_p);
		res_s = st.en[`VFP_T_RES] & ~blk.res
			& (volt.res > st.res_thr);

		// Period measurement in microseconds
		// Resolution is 1 us; two periods count as identical for
		// acceptance only when they give the same whole-us count
		// A missing crossing ends the period at the longest legal
		// value, so a dead input still runs the invalid count
		tout = 1'b0;
		per = st.per_cnt;
		if (zero_cross)
		begin
			next_st.us_sub = '0;
			next_st.per_cnt = '0;
			next_st.armed = 1'b1;
		end
		else if (st.us_sub == US_LAST)
		begin
			next_st.us_sub = '0;
			if (st.per_cnt == PER_MAX)
			begin
				tout = 1'b1;
				next_st.per_cnt = '0;
			end
			else
				next_st.per_cnt = st.per_cnt + 16'h0001;
		end
		else
			next_st.us_sub = st.us_sub + 8'h01;
		// A dip at any time during the period spoils that period
		zc_ok = zero_cross & st.armed & ~st.low_seen
			& (volt.ph[0] > `VFP_EVAL_PCT)
			& (per >= PER_MIN) & (per <= PER_MAX);
		if (zero_cross | tout)
			next_st.low_seen = volt.ph[0] <= `VFP_EVAL_PCT;
		else if (volt.ph[0] <= `VFP_EVAL_PCT)
			next_st.low_seen = 1'b1;

		if (zero_cross | tout)
		begin
			if (zc_ok)
			begin
				next_st.inv_cnt = '0;
				next_st.last_per = per;
				next_st.same_cnt = (per == st.last_per)
					? inc_sat(st.same_cnt, `VFP_ACCEPT_CNT)
					: 3'h1;
				if (next_st.same_cnt >= `VFP_ACCEPT_CNT)
					next_st.acc_per = per;
			end
			else
			begin
				next_st.same_cnt = '0;
				next_st.inv_cnt = inc_sat(st.inv_cnt, `VFP_INVALID_CNT);
				if (next_st.inv_cnt >= `VFP_INVALID_CNT)
					next_st.acc_per = '0;
			end
			// f > setting is period * setting below 1e8 cHz*us
			prod = 29'(next_st.acc_per) * 29'(st.of_thr);
			if ((next_st.acc_per != '0)
				&& (32'(prod) < `VFP_CHZ_US))
				next_st.over_cnt = inc_sat(st.over_cnt, `VFP_OF_CNT);
			else
				next_st.over_cnt = '0;
		end
		if (~st.en[`VFP_T_OF])
			next_st.over_cnt = '0;
		of_s = st.en[`VFP_T_OF] & ~blk.of
			& (next_st.over_cnt >= `VFP_OF_CNT);

		// Definite delays and trips
		// Trips compare the registered timer, so they lag the timer
		// by one cycle; a delay of 0 trips together with the start
		next_st.tmr[`VFP_T_OV] = tmr_step(st.tmr[`VFP_T_OV], ov_g);
		next_st.tmr[`VFP_T_UV] = tmr_step(st.tmr[`VFP_T_UV], uv_g);
		next_st.tmr[`VFP_T_RES] = tmr_step(st.tmr[`VFP_T_RES], res_s);
		next_st.tmr[`VFP_T_OF] = tmr_step(st.tmr[`VFP_T_OF], of_s);
		next_st.out.ov_start = ov_p;
		next_st.out.ov_gen = ov_g;
		next_st.out.ov_trip = ov_g & ~st.so[`VFP_T_OV]
			& (st.tmr[`VFP_T_OV].ms >= st.dly[`VFP_T_OV]);
		next_st.out.uv_start = uv_p;
		next_st.out.uv_gen = uv_g;
		next_st.out.uv_trip = uv_g & ~st.so[`VFP_T_UV]
			& (st.tmr[`VFP_T_UV].ms >= st.dly[`VFP_T_UV]);
		next_st.out.res_start = res_s;
		next_st.out.res_trip = res_s & ~st.so[`VFP_T_RES]
			& (st.tmr[`VFP_T_RES].ms >= st.dly[`VFP_T_RES]);
		next_st.out.of_start = of_s;
		next_st.out.of_trip = of_s & ~st.so[`VFP_T_OF]
			& (st.tmr[`VFP_T_OF].ms >= st.dly[`VFP_T_OF]);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st <= RST_STATE;
		else
			st <= next_st;
	end
endmodule : vfp_top

/* File: bench/vfp_checker.sv */
// Port assertions for the protection block
`timescale 1ns/10ps
module vfp_checker (
	// Clock, reset, bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Protection side
	input wire vfp_pkg::vfp_volt_s volt,
	input wire vfp_pkg::vfp_blk_s blk,
	input wire vfp_pkg::vfp_out_s prot
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	ov_block_a: assert property (blk.ov |=> prot[4:0] == '0)
		else $error("ov outputs not blocked");
	uv_block_a: assert property (blk.uv |=> prot[9:5] == '0)
		else $error("uv outputs not blocked");
	res_block_a: assert property (blk.res |=> prot[11:10] == '0)
		else $error("res outputs not blocked");
	of_block_a: assert property (blk.of |=> prot[13:12] == '0)
		else $error("of outputs not blocked");
	ov_general_a: assert property (prot.ov_gen == |prot.ov_start)
		else $error("ov general start wrong");
	ov_level_a: assert property (prot.ov_start[0] |->
		$past(volt.ph[0]) > 8'h1E) else $error("ov start too low");
	uv_level_a: assert property (prot.uv_start[0] |->
		$past(volt.ph[0]) < 8'h82) else $error("uv start too high");
	trip_start_a: assert property (prot.ov_trip |->
		prot.ov_gen || $past(prot.ov_gen)) else $error("trip alone");
	ready_pulse_a: assert property (psel && $rose(penable) |=>
		pready ##1 !pready) else $error("pready timing");
	rdata_idle_a: assert property (!pready |-> prdata == '0)
		else $error("stray read data");
	cover property (prot.ov_trip);
	cover property (prot.uv_gen);
	cover property (prot.res_trip);
endmodule : vfp_checker
bind vfp_top vfp_checker chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
	.volt(volt), .blk(blk), .prot(prot));

/* File: bench/vfp_meas_model.sv */
// Upstream magnitude and zero crossing source
`timescale 1ns/10ps
module vfp_meas_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Requested magnitudes, crossing period (0 stops)
	input wire vfp_pkg::vfp_volt_s vset,
	input wire logic [7:0] per,
	// Towards the block
	output vfp_pkg::vfp_volt_s volt,
	output logic zero_cross
);
	logic [7:0] cnt;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			volt <= '0;
			cnt <= '0;
			zero_cross <= 1'b0;
		end
		else
		begin
			volt <= vset;
			cnt <= (cnt >= per) ? 8'h00 : cnt + 8'h01;
			// One-cycle pulse per crossing
			zero_cross <= (per != 8'h00) && (cnt == per);
		end
	end
endmodule : vfp_meas_model

/* File: bench/testbench.sv */
// Self-checking bench for the protection block
`timescale 1ns/10ps
module testbench;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	vfp_pkg::vfp_volt_s vset = '0;
	vfp_pkg::vfp_volt_s volt;
	vfp_pkg::vfp_blk_s blk = '0;
	vfp_pkg::vfp_out_s prot;
	logic [7:0] per = '0;
	logic zero_cross;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [31:0] q;
	logic e;
	int n;
	always #2.5 pclk = ~pclk;
	vfp_meas_model src_u (.pclk(pclk), .presetn(presetn), .vset(vset),
		.per(per), .volt(volt), .zero_cross(zero_cross));
	vfp_top #(.TICK_CYCLES(10)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .volt(volt), .blk(blk),
		.zero_cross(zero_cross), .prot(prot));
	task automatic test_done;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			test_done;
		end
	end
	task automatic chk(input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x)
		begin
			failures++;
			$display("mismatch at %0t: got %h exp %h", $time, g, x);
		end
	endtask : chk
	// Called just after a rising edge; holds request until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// Cycles until a prot bit rises, 200 means never
	task automatic until_hi(input int b);
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (prot[b] !== 1'b1 && n < 200);
	endtask : until_hi
	task automatic t_regs;
		logic [7:0] a [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
			8'h18, 8'h1C, 8'h20};
		logic [31:0] x [9] = '{32'h001D, 32'h003F, 32'h0A34, 32'h001E,
			32'h13EC, 32'h0064, 32'h0064, 32'h0064, 32'h00C8};
		for (int i = 0; i < 9; i++)
		begin
			apb(1'b0, a[i], '0);
			chk(x[i], q);
		end
		apb(1'b1, 8'h04, 32'h00C8);
		apb(1'b0, 8'h04, '0);
		chk(32'h0082, q);
		apb(1'b1, 8'h04, 32'h003F);
		apb(1'b0, 8'h30, '0);
		chk(32'h0001, {31'h0, e});
	endtask : t_regs
	task automatic t_ov;
		apb(1'b1, 8'h14, 32'h0003);
		vset.ph[0] <= 8'h40;
		repeat (20) @(posedge pclk);
		vset.ph[0] <= 8'h00;
		repeat (3) @(posedge pclk);
		vset.ph[0] <= 8'h40;
		until_hi(4);
		chk(32'h1, 32'(n >= 31 && n <= 36));
		chk(32'h1, {31'h0, prot.ov_gen});
		apb(1'b1, 8'h00, 32'h003D);
		until_hi(4);
		chk(32'd200, n);
		blk.ov <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(32'h0, {27'h0, prot[4:0]});
		blk.ov <= 1'b0;
		vset.ph[0] <= 8'h00;
		apb(1'b1, 8'h00, 32'h001D);
	endtask : t_ov
	task automatic t_uv;
		logic [3:0] g = 4'b0010;
		vset.ph <= {8'h64, 8'h64, 8'h28};
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, 8'h00, 32'h001C | m);
			repeat (3) @(posedge pclk);
			chk({31'h0, g[m]}, {31'h0, prot.uv_gen});
		end
		apb(1'b1, 8'h00, 32'h001D);
		chk(32'h1, {29'h0, prot.uv_start});
		vset.ph[0] <= 8'h05;
		repeat (3) @(posedge pclk);
		chk(32'h0, {29'h0, prot.uv_start});
		vset <= '0;
	endtask : t_uv
	task automatic t_res;
		apb(1'b1, 8'h1C, 32'h0000);
		vset.res <= 8'h1E;
		repeat (4) @(posedge pclk);
		chk(32'h0, {31'h0, prot.res_start});
		vset.res <= 8'h1F;
		until_hi(11);
		chk(32'h1, 32'(n <= 4));
		blk.res <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(32'h0, {30'h0, prot[11:10]});
		blk.res <= 1'b0;
		vset <= '0;
	endtask : t_res
	task automatic t_freq;
		vset.ph[0] <= 8'h64;
		per <= 8'h32;
		repeat (400) @(posedge pclk);
		apb(1'b0, 8'h28, '0);
		chk(32'h0, q);
		chk(32'h0, {30'h0, prot[13:12]});
	endtask : t_freq
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_ov;
		t_uv;
		t_res;
		t_freq;
		test_done;
	end
endmodule : testbench
